// [hw/hall_switch_pkg.sv]
// Shared constants and types for the duty-cycled magnetic switch sampler
package hall_switch_pkg;

  // Clock rate
  localparam int unsigned REF_CLK_HZ     = 200_000_000;
  localparam int unsigned NS_PER_S       = 1_000_000_000;
  localparam int unsigned REF_CLK_PER_NS = NS_PER_S / REF_CLK_HZ;

  // Sample periods, nominal, in ms
  localparam int unsigned PERIOD_FAST_MS = 50;
  localparam int unsigned PERIOD_SLOW_MS = 200;
  localparam int unsigned NS_PER_MS      = 1_000_000;
  localparam int unsigned PERIOD_FAST_CYC = PERIOD_FAST_MS * (NS_PER_MS / REF_CLK_PER_NS);
  localparam int unsigned PERIOD_SLOW_CYC = PERIOD_SLOW_MS * (NS_PER_MS / REF_CLK_PER_NS);

  // Power-on and active windows, in us
  localparam int unsigned NS_PER_US      = 1000;
  localparam int unsigned TON_NOM_US     = 55;
  localparam int unsigned TON_MAX_US     = 100;
  localparam int unsigned TACTIVE_US     = 40;
  localparam int unsigned TON_NOM_CYC    = TON_NOM_US * NS_PER_US / REF_CLK_PER_NS;
  localparam int unsigned TON_MAX_CYC    = TON_MAX_US * NS_PER_US / REF_CLK_PER_NS;
  localparam int unsigned TACTIVE_CYC    = TACTIVE_US * NS_PER_US / REF_CLK_PER_NS;

  // Widths
  localparam int unsigned CNT_W   = 27;
  localparam int unsigned FLUX_W  = 16;
  localparam int unsigned SYNC_W  = 3;

  // Flux in signed 0.01 mT steps; largest operate point 63 mT
  localparam logic signed [FLUX_W-1:0] OP_THR_MAX = 16'sh189c;
  localparam logic signed [FLUX_W-1:0] OP_THR_DEF = 16'sh012c;
  localparam logic signed [FLUX_W-1:0] RP_THR_DEF = 16'sh0096;

  // Build options
  typedef enum logic {RESP_OMNI = 1'b0, RESP_UNI = 1'b1} resp_t;
  typedef enum logic {DRV_PUSH_PULL = 1'b0, DRV_OPEN_DRAIN = 1'b1} drv_t;
  typedef enum logic {RATE_20HZ = 1'b0, RATE_5HZ = 1'b1} rate_t;

  // Sequencer states
  typedef enum logic [2:0]
  {
    ST_POWERON = 3'b001,
    ST_ACTIVE  = 3'b010,
    ST_SLEEP   = 3'b100
  } seq_state_t;

  // One output pin, drive signals only: o and oe
  typedef struct packed
  {
    logic o;
    logic oe;
  } pin_drv_t;

endpackage

// [hw/hall_switch_cmp.sv]
// Hysteresis comparator for one active-low switch channel
`timescale 1ns/1ps
module hall_switch_cmp
  import hall_switch_pkg::*;
(
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  // Evaluation
  input  wire logic                     eval_stb,
  input  wire logic signed [FLUX_W-1:0] flux_val,
  input  wire logic signed [FLUX_W-1:0] operate_threshold,
  input  wire logic signed [FLUX_W-1:0] release_threshold,
  // Latched state, high means field detected
  output logic                          detect_ff
);

  // Operate above the upper point, release below the lower one
  wire logic op_hit  = flux_val > operate_threshold;
  wire logic rel_hit = flux_val < release_threshold;
  // Only a changed decision moves the latch, so a steady field never glitches
  wire logic nxt_detect = detect_ff ? ~rel_hit : op_hit;

  // Latch updates only at sample end
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      detect_ff <= 1'b0;
    else if (eval_stb)
      detect_ff <= nxt_detect;
  end

endmodule

// [hw/hall_switch_sampler.sv]
// Duty-cycled magnetic switch sampler: sequencer, polarity logic, output drivers
// Function
// - Upward flux positive, downward negative
// - Build options: response, driver, rate, threshold
// - Omnipolar output reacts to flux magnitude
// - Unipolar: north negative, south positive only
// - Push-pull always drives high or low
// - Open-drain pulls low or releases; host pullup
// - First sample sets output within power-on
// - Output latched, then sensing path sleeps
// - Wake each period, resample, update on change
// - Steady field gives no toggle
// - Operate above upper, release below lower
// - Open-drain outputs wire-AND on shared node
// - Unipolar dual: zero field both high
// - Period 50 ms fast, 200 ms slow
// - Power-on within 100 us, nominal 55
// - Active window nominally 40 us
`timescale 1ns/1ps
module hall_switch_sampler
  import hall_switch_pkg::*;
#(
  parameter resp_t                     RESP_MODE  = RESP_OMNI,
  parameter drv_t                      DRV_MODE   = DRV_PUSH_PULL,
  parameter rate_t                     RATE_MODE  = RATE_20HZ,
  parameter logic signed [FLUX_W-1:0]  OP_THR     = OP_THR_DEF,
  parameter logic signed [FLUX_W-1:0]  RP_THR     = RP_THR_DEF,
  parameter int unsigned               PERIOD_CYC = (RATE_MODE == RATE_5HZ) ?
                                                    PERIOD_SLOW_CYC : PERIOD_FAST_CYC,
  parameter int unsigned               TON_CYC    = TON_NOM_CYC,
  parameter int unsigned               ACTIVE_CYC = TACTIVE_CYC
)
(
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  // Sensed flux from the front end, signed, asynchronous
  input  wire logic signed [FLUX_W-1:0] flux_in,
  // Sensing path power request
  output logic                          sense_en,
  // North output pin
  input  wire logic                     north_output_i,
  output logic                          north_output_o,
  output logic                          north_output_oe,
  // South output pin
  input  wire logic                     south_output_i,
  output logic                          south_output_o,
  output logic                          south_output_oe,
  // Status
  output logic                          first_done,
  output logic                          sample_stb
);

  // Terminal counts, one below each length; operate point clamped to OP_THR_MAX
  localparam logic [CNT_W-1:0] PER_TC = CNT_W'(PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] TON_TC = CNT_W'(TON_CYC - 1);
  localparam logic [CNT_W-1:0] ACT_TC = CNT_W'(ACTIVE_CYC - 1);
  localparam logic signed [FLUX_W-1:0] OP_USE = (OP_THR > OP_THR_MAX) ? OP_THR_MAX : OP_THR;

  // Flux synchroniser, three stages; word assumed stable while active
  logic signed [FLUX_W-1:0] flux_s1_ff;
  logic signed [FLUX_W-1:0] flux_s2_ff;
  logic signed [FLUX_W-1:0] flux_s3_ff;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      flux_s1_ff <= '0;
      flux_s2_ff <= '0;
      flux_s3_ff <= '0;
    end
    else
    begin
      flux_s1_ff <= flux_in;
      flux_s2_ff <= flux_s1_ff;
      flux_s3_ff <= flux_s2_ff;
    end
  end

  // Settled flux word: taken only when second and third stages agree
  logic signed [FLUX_W-1:0] flux_ok_ff;
  wire logic flux_agree = (flux_s2_ff == flux_s3_ff);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      flux_ok_ff <= '0;
    else if (flux_agree)
      flux_ok_ff <= flux_s3_ff;
  end

  // Sequencer
  seq_state_t       state_ff;
  seq_state_t       nxt_state;
  logic [CNT_W-1:0] phase_ff;
  logic [CNT_W-1:0] per_ff;
  logic             first_ff;

  wire logic on_end  = (state_ff == ST_POWERON) && (phase_ff == TON_TC);
  wire logic act_end = (state_ff == ST_ACTIVE) && (phase_ff == ACT_TC);
  wire logic per_end = (per_ff == PER_TC);
  wire logic eval    = on_end || act_end;

  // Next state; a period end always wakes the sensing path
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POWERON: if (on_end) nxt_state = ST_SLEEP;
      ST_ACTIVE:  if (act_end) nxt_state = ST_SLEEP;
      ST_SLEEP:   if (per_end) nxt_state = ST_ACTIVE;
      default:    nxt_state = ST_POWERON;
    endcase
  end

  // Phase counter restarts on every state change
  wire logic [CNT_W-1:0] nxt_phase = (nxt_state != state_ff) ? '0 : phase_ff + 1'b1;
  // Period counter free runs from the first latch, wraps at terminal count
  wire logic [CNT_W-1:0] nxt_per = (on_end || per_end) ? '0 : per_ff + 1'b1;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_POWERON;
      phase_ff <= '0;
      per_ff   <= '0;
      first_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      per_ff   <= nxt_per;
      if (on_end)
        first_ff <= 1'b1;
    end
  end

  // Polarity: positive is upward flux, south pole at the top
  // Negation saturates: full-scale north would otherwise wrap to itself and be missed
  localparam logic signed [FLUX_W-1:0] FLUX_POS_MAX = {1'b0, {(FLUX_W-1){1'b1}}};
  wire logic flux_at_min = (flux_ok_ff == ~FLUX_POS_MAX);
  wire logic signed [FLUX_W-1:0] flux_neg = flux_at_min ? FLUX_POS_MAX : -flux_ok_ff;
  wire logic signed [FLUX_W-1:0] flux_mag = flux_ok_ff[FLUX_W-1] ? flux_neg : flux_ok_ff;
  // Omnipolar uses magnitude; unipolar south sees the signed value
  wire logic signed [FLUX_W-1:0] south_flux = (RESP_MODE == RESP_OMNI) ?
                                              flux_mag : flux_ok_ff;
  wire logic signed [FLUX_W-1:0] north_flux = flux_neg;

  logic south_det;
  logic north_det;

  // South, or the single omnipolar channel
  hall_switch_cmp south_cmp
  (
    .ref_clk           (ref_clk),
    .sys_rst           (sys_rst),
    .eval_stb          (eval),
    .flux_val          (south_flux),
    .operate_threshold (OP_USE),
    .release_threshold (RP_THR),
    .detect_ff         (south_det)
  );

  // North channel, negated flux so thresholds stay positive
  hall_switch_cmp north_cmp
  (
    .ref_clk           (ref_clk),
    .sys_rst           (sys_rst),
    .eval_stb          (eval),
    .flux_val          (north_flux),
    .operate_threshold (OP_USE),
    .release_threshold (RP_THR),
    .detect_ff         (north_det)
  );

  // Omnipolar drives both pins from one decision; unipolar splits them
  wire logic north_act = (RESP_MODE == RESP_OMNI) ? south_det : north_det;
  wire logic south_act = south_det;

  // Pin driver: low when detected, else high or released
  function automatic pin_drv_t drive_pin(input logic act);
    pin_drv_t p;
    p.o  = ~act;
    p.oe = (DRV_MODE == DRV_PUSH_PULL) ? 1'b1 : act;
    return p;
  endfunction

  // Registered pin drive, deasserted until first sample latches
  pin_drv_t north_pin_ff;
  pin_drv_t south_pin_ff;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      north_pin_ff <= '{o: 1'b1, oe: 1'b1};
      south_pin_ff <= '{o: 1'b1, oe: 1'b1};
    end
    else
    begin
      north_pin_ff <= drive_pin(north_act & first_ff);
      south_pin_ff <= drive_pin(south_act & first_ff);
    end
  end

  // Released open-drain pin must not drive during reset
  wire logic rst_oe = (DRV_MODE == DRV_PUSH_PULL);

  assign north_output_o  = north_pin_ff.o;
  assign north_output_oe = north_pin_ff.oe & (rst_oe | ~north_pin_ff.o);
  assign south_output_o  = south_pin_ff.o;
  assign south_output_oe = south_pin_ff.oe & (rst_oe | ~south_pin_ff.o);

  // Status
  assign sense_en   = (state_ff != ST_SLEEP);
  assign first_done = first_ff;
  assign sample_stb = eval;

  // Pin readback unused: the shared node level is the host's concern
  wire logic unused_pins = north_output_i ^ south_output_i;

endmodule

// [verification/host_gpio_model.sv]
// Host input model: pullups on the pins and one shared wired-AND node
`timescale 1ns/1ps
module host_gpio_model
  import hall_switch_pkg::*;
(
  // Sensor pins
  input  wire pin_drv_t north_pin,
  input  wire pin_drv_t south_pin,
  // Levels the host reads
  output logic          north_lvl,
  output logic          south_lvl,
  output logic          shared_lvl
);
  // A released pin reads high through the pullup
  assign north_lvl  = north_pin.oe ? north_pin.o : 1'b1;
  assign south_lvl  = south_pin.oe ? south_pin.o : 1'b1;
  // Any low driver wins on the shared node
  assign shared_lvl = north_lvl & south_lvl;
endmodule

// [verification/hall_switch_sampler_props.sv]
// Concurrent checks on pin drive, sequencing and sample spacing
`timescale 1ns/1ps
module hall_switch_sampler_props
  import hall_switch_pkg::*;
#(
  parameter drv_t        DRV_MODE   = DRV_PUSH_PULL,
  parameter int unsigned PERIOD_CYC = 64,
  parameter int unsigned TON_CYC    = 8,
  parameter int unsigned ACTIVE_CYC = 4
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Sequencer
  input wire logic sense_en,
  input wire logic first_done,
  input wire logic sample_stb,
  // Pins
  input wire logic north_output_o,
  input wire logic north_output_oe,
  input wire logic south_output_o,
  input wire logic south_output_oe
);
  localparam int PER  = PERIOD_CYC;
  localparam int TLIM = TON_CYC + 2;
  localparam int ACT  = ACTIVE_CYC - 1;
  localparam logic OD = (DRV_MODE == DRV_OPEN_DRAIN);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Pins move only as the outcome of a sample
  north_move_a: assert property ($changed(north_output_o) |-> $past(sample_stb, 2))
    else $error("north pin moved without a sample");
  south_move_a: assert property ($changed(south_output_o) |-> $past(sample_stb, 2))
    else $error("south pin moved without a sample");
  // Open-drain only ever drives low
  pin_drive_a: assert property ((north_output_oe == (OD ? !north_output_o : 1'b1))
    && (south_output_oe == (OD ? !south_output_o : 1'b1))) else $error("bad pin enable");
  idle_high_a: assert property (!first_done |-> north_output_o && south_output_o)
    else $error("pin asserted before first sample");
  first_src_a: assert property ($rose(first_done) |-> $past(sample_stb))
    else $error("first flag without a sample");
  power_on_a: assert property ($fell(sys_rst) |-> ##[1:TLIM] first_done)
    else $error("first sample late");
  period_a: assert property (sample_stb && first_done |-> ##[PER:PER] sample_stb)
    else $error("sample spacing wrong");
  stb_gap_a: assert property (sample_stb |=> !sample_stb [*8])
    else $error("samples too close");
  sleep_a: assert property (sample_stb |=> !sense_en)
    else $error("no sleep after sample");
  active_a: assert property ($rose(sense_en) && first_done |-> ##[ACT:ACT] sample_stb)
    else $error("active window length wrong");
  cover property ($fell(north_output_o));
  cover property ($fell(south_output_o));
  cover property (sample_stb && first_done);
endmodule
bind hall_switch_sampler hall_switch_sampler_props #(.DRV_MODE(DRV_MODE),
  .PERIOD_CYC(PERIOD_CYC), .TON_CYC(TON_CYC), .ACTIVE_CYC(ACTIVE_CYC))
  hall_switch_sampler_props_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .sense_en(sense_en),
  .first_done(first_done), .sample_stb(sample_stb), .north_output_o(north_output_o),
  .north_output_oe(north_output_oe), .south_output_o(south_output_o),
  .south_output_oe(south_output_oe));

// [verification/tb.sv]
// Bench: unipolar open-drain and omnipolar push-pull builds on one flux
`timescale 1ns/1ps
module tb;
  import hall_switch_pkg::*;
  localparam int P  = 64;
  localparam int OP = OP_THR_DEF;
  localparam int RP = RP_THR_DEF;
  localparam int FS = -(2**(FLUX_W-1));
  // Boundary sweep: strict thresholds, hysteresis, pole swap, full-scale north held steady
  localparam int FT [14] = '{0, OP, OP+1, RP, RP-1, -OP, -OP-1, -RP, -RP+1, OP+1, -OP-1, 0,
                             FS, FS};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic signed [FLUX_W-1:0] flux_in = '0;
  wire pin_drv_t un, us, mn, ms;
  logic u_nl, u_sl, u_sh, m_nl, m_sl, u_stb, u_done;
  logic dn = 1'b0, ds = 1'b0, dm = 1'b0;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  hall_switch_sampler #(.RESP_MODE(RESP_UNI), .DRV_MODE(DRV_OPEN_DRAIN), .PERIOD_CYC(P),
    .TON_CYC(8), .ACTIVE_CYC(4)) hall_switch_sampler_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .flux_in(flux_in), .sense_en(), .north_output_i(u_nl), .north_output_o(un.o),
    .north_output_oe(un.oe), .south_output_i(u_sl), .south_output_o(us.o),
    .south_output_oe(us.oe), .first_done(u_done), .sample_stb(u_stb));
  hall_switch_sampler #(.RATE_MODE(RATE_5HZ), .PERIOD_CYC(P), .TON_CYC(8), .ACTIVE_CYC(4))
    hall_switch_sampler_pp_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .flux_in(flux_in),
    .sense_en(), .north_output_i(m_nl), .north_output_o(mn.o), .north_output_oe(mn.oe),
    .south_output_i(m_sl), .south_output_o(ms.o), .south_output_oe(ms.oe),
    .first_done(), .sample_stb());
  host_gpio_model host_gpio_model_i (.north_pin(un), .south_pin(us), .north_lvl(u_nl),
    .south_lvl(u_sl), .shared_lvl(u_sh));
  host_gpio_model host_gpio_model_pp_i (.north_pin(mn), .south_pin(ms), .north_lvl(m_nl),
    .south_lvl(m_sl), .shared_lvl());
  // Reference hysteresis: strict compare on both points
  function automatic logic hyst(input logic d, input int x);
    return (x > OP) ? 1'b1 : ((x < RP) ? 1'b0 : d);
  endfunction
  task automatic chk(input string nm, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // Wait for a sample strobe, then for the pin register to take it
  task automatic step();
    int n;
    n = 0;
    while (u_stb !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 200)
      n_mismatch++;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, far above the power-on window and thirteen sample periods needed
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("north_idle", 1'b1, u_nl);
    chk("south_idle", 1'b1, u_sl);
    chk("omni_idle", 1'b1, m_nl);
    $display("test reset done");
    for (int i = 0; i < 14; i++)
    begin
      flux_in = FLUX_W'(FT[i]);
      ds = hyst(ds, FT[i]);
      dn = hyst(dn, -FT[i]);
      dm = hyst(dm, (FT[i] < 0) ? -FT[i] : FT[i]);
      step();
      chk("north_uni", !dn, u_nl);
      chk("south_uni", !ds, u_sl);
      chk("shared_node", !(dn | ds), u_sh);
      chk("north_omni", !dm, m_nl);
      chk("south_omni", !dm, m_sl);
      chk("first_done", 1'b1, u_done);
    end
    $display("test sweep done");
    test_done();
  end
endmodule
